// ==== core/pica_consts.svh ====
// Offsets, field positions, reset values and bus codes of the indirect access block.
`ifndef PICA_CONSTS_SVH
`define PICA_CONSTS_SVH

// Register byte offsets.
`define PICA_LO_DATA_ADDR_OFF 12'h610
`define PICA_LO_CTRL_OFF      12'h614
`define PICA_HI_DATA_ADDR_OFF 12'h618
`define PICA_HI_CTRL_OFF      12'h61C
`define PICA_IRQ_STATUS_OFF   12'h620
`define PICA_IRQ_CLEAR_OFF    12'h624
`define PICA_IRQ_ENABLE_OFF   12'h628

// Data and address word fields.
`define PICA_DATA_MSB 31
`define PICA_DATA_LSB 16
`define PICA_ADDR_MSB 15
`define PICA_ADDR_LSB 0

// Control word fields.
`define PICA_CTRL_RW    0
`define PICA_CTRL_DIS   1
`define PICA_CTRL_DONE  2
`define PICA_CTRL_STLSB 3
`define PICA_CTRL_STMSB 5
`define PICA_CTRL_RST   6

// Reset values and bus answers.
`define PICA_WORD_RST  32'h0000_0000
`define PICA_IRQ_RST   2'h0
`define PICA_RESP_OKAY 2'h0
`define PICA_RESP_SLV  2'h2

`endif

// ==== core/pica_pkg.sv ====
// Types shared by the indirect access block and its users.
package pica_pkg;

  // Access engine states, shown in control bits 5:3.
  typedef enum logic [2:0] {
    PICA_IDLE = 3'b000,
    PICA_BUSY = 3'b001,
    PICA_DONE = 3'b010
  } pica_state_t;

  // Request toward the PHY internal register port of one lane group.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pica_phy_req_t;

  // Answer from the PHY internal register port of one lane group.
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } pica_phy_rsp_t;

endpackage : pica_pkg

// ==== core/pica_phy_indirect_access.sv ====
// Indirect PHY register access engine for two lane groups behind an AXI4-Lite slave.
//
// Operation
// - Two independent register pairs: lower lanes 0-3 and upper lanes 4-7.
// - First word holds PHY data in 31:16 and PHY address in 15:0, both RW.
// - A finished PHY read places the returned value into the data field.
// - Control bit 0 selects direction: 0 reads the PHY, 1 writes it.
// - With control bit 1 clear, any read or write of the pair launches an access.
// - With control bit 1 set, pair accesses only store or return register contents.
// - Control bit 2 is set when one PHY access has finished.
// - Control bit 6 high holds the access engine in its reset state.
// - Control bits 5:3 are read-only and show the engine state.
// - Every word of both pairs resets to zero.
//
// Each lane group owns one engine. A launch copies direction, address and write data into
// the request toward the PHY port, which stands until the port answers; the engine then
// shows done for one cycle and falls back to idle. Launches that arrive while an access
// is under way are dropped without an error, so software must poll the done flag or the
// interrupt before it touches the pair again.
//
// Three words beyond the pairs carry the completion events: a read-only status word, a
// write-one-to-clear word and an enable word. A completion that meets a clear in the same
// cycle stays set, so no event is lost. Writes to the status word and reads of the clear
// word, as well as any unmapped place, answer with a slave error and change nothing.
//
// Reading the control word launches an access just as writing it does; a read that
// launches returns the contents from before the launch.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pica_consts.svh"

module pica_phy_indirect_access #(
  parameter int ADDR_W = 12,
  parameter int GROUPS = 2
) (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output var  logic                                s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output var  logic                                s_axi_wready,
  output var  logic [1:0]                          s_axi_bresp,
  output var  logic                                s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output var  logic                                s_axi_arready,
  output var  logic [31:0]                         s_axi_rdata,
  output var  logic [1:0]                          s_axi_rresp,
  output var  logic                                s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output var  pica_pkg::pica_phy_req_t [GROUPS-1:0] phy_req,
  input  wire pica_pkg::pica_phy_rsp_t [GROUPS-1:0] phy_rsp,
  output var  logic                                irq
);
  import pica_pkg::*;

  // Register index decode: 0..3 are the pair words, 4..6 interrupt words, 7 unmapped.
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [11:0] off;
    off = 12'(a);
    if (off == `PICA_LO_DATA_ADDR_OFF)    reg_index = 3'h0;
    else if (off == `PICA_LO_CTRL_OFF)      reg_index = 3'h1;
    else if (off == `PICA_HI_DATA_ADDR_OFF) reg_index = 3'h2;
    else if (off == `PICA_HI_CTRL_OFF)      reg_index = 3'h3;
    else if (off == `PICA_IRQ_STATUS_OFF)   reg_index = 3'h4;
    else if (off == `PICA_IRQ_CLEAR_OFF)    reg_index = 3'h5;
    else if (off == `PICA_IRQ_ENABLE_OFF)   reg_index = 3'h6;
    else                                    reg_index = 3'h7;
  endfunction : reg_index

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // Tells whether a bus access to a decoded place is refused with an error answer.
  function automatic logic refused(input logic [2:0] idx, input logic is_write);
    logic res;
    res = (idx == 3'h7);
    if (is_write && (idx == 3'h4)) begin
      res = 1'b1;
    end
    if (!is_write && (idx == 3'h5)) begin
      res = 1'b1;
    end
    refused = res;
  endfunction : refused

  // Shows a control word as software reads it, with the live engine state in its field.
  function automatic logic [31:0] ctrl_view(input logic [31:0] ctrl, input pica_state_t st);
    logic [31:0] res;
    res = ctrl;
    res[`PICA_CTRL_STMSB:`PICA_CTRL_STLSB] = st;
    ctrl_view = res;
  endfunction : ctrl_view

  // Decoded index of one word of a lane group's pair: data word first, control word second.
  function automatic logic [2:0] pair_index(input int grp, input logic is_ctrl);
    logic [2:0] res;
    res = 3'(2 * grp);
    if (is_ctrl) begin
      res = res | 3'h1;
    end
    pair_index = res;
  endfunction : pair_index

  // Bus-side holding registers.
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;

  // Pair words, engine state and interrupt registers.
  logic [31:0]          data_addr_reg [GROUPS];
  logic [31:0]          ctrl_reg      [GROUPS];
  pica_state_t          state_reg     [GROUPS];
  logic [GROUPS-1:0]    irq_status_reg;
  logic [GROUPS-1:0]    irq_enable_reg;

  // Combinational helpers.
  logic              wr_fire;
  logic              rd_fire;
  logic [2:0]        wr_idx;
  logic [2:0]        rd_idx;
  logic [GROUPS-1:0] launch;
  logic [GROUPS-1:0] finish;
  logic [GROUPS-1:0] irq_status_next;
  logic [31:0]       data_addr_next [GROUPS];
  logic [31:0]       ctrl_next      [GROUPS];
  logic [31:0]       rd_word;

  // A write is done once address and data are both held and no response is pending.
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx  = reg_index(awaddr_reg);
  assign rd_idx  = reg_index(s_axi_araddr);

  // Per-group next values, launch and completion decisions.
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      logic touch;
      logic wr_ctrl;
      touch   = 1'b0;
      wr_ctrl = wr_fire && (wr_idx == pair_index(g, 1'b1));
      data_addr_next[g] = data_addr_reg[g];
      ctrl_next[g]      = ctrl_reg[g];
      if (wr_fire && (wr_idx == pair_index(g, 1'b0))) begin
        data_addr_next[g] = merge(data_addr_reg[g], wdata_reg, wstrb_reg);
      end
      if (wr_ctrl) begin
        ctrl_next[g] = merge(ctrl_reg[g], wdata_reg, wstrb_reg);
      end
      ctrl_next[g][`PICA_CTRL_STMSB:`PICA_CTRL_STLSB] = 3'h0;
      touch = (wr_fire && (wr_idx[2:1] == 2'(g))) || (rd_fire && (rd_idx[2:1] == 2'(g)));
      // Launch uses the control value in force after this access.
      launch[g] = touch && !ctrl_next[g][`PICA_CTRL_DIS]
                  && !ctrl_next[g][`PICA_CTRL_RST]
                  && (state_reg[g] == PICA_IDLE);
      finish[g] = (state_reg[g] == PICA_BUSY) && phy_rsp[g].ack && !ctrl_reg[g][`PICA_CTRL_RST];
      if (finish[g] && !phy_req[g].write) begin
        data_addr_next[g][`PICA_DATA_MSB:`PICA_DATA_LSB] = phy_rsp[g].rdata;
      end
      if (finish[g]) begin
        ctrl_next[g][`PICA_CTRL_DONE] = 1'b1;
      end else if (launch[g]) begin
        ctrl_next[g][`PICA_CTRL_DONE] = 1'b0;
      end
    end
  end

  // Pair word storage.
  always_ff @(posedge aclk) begin
    for (int g = 0; g < GROUPS; g++) begin
      if (!aresetn) begin
        data_addr_reg[g] <= `PICA_WORD_RST;
        ctrl_reg[g]      <= `PICA_WORD_RST;
      end else begin
        data_addr_reg[g] <= data_addr_next[g];
        ctrl_reg[g]      <= ctrl_next[g];
      end
    end
  end

  // Access engine per lane group: idle, waiting for the PHY, one cycle of done.
  always_ff @(posedge aclk) begin
    for (int g = 0; g < GROUPS; g++) begin
      if (!aresetn || ctrl_reg[g][`PICA_CTRL_RST]) begin
        state_reg[g] <= PICA_IDLE;
      end else begin
        case (state_reg[g])
          PICA_IDLE: begin
            if (launch[g]) begin
              state_reg[g] <= PICA_BUSY;
            end
          end
          PICA_BUSY: begin
            if (finish[g]) begin
              state_reg[g] <= PICA_DONE;
            end
          end
          default: begin
            state_reg[g] <= PICA_IDLE;
          end
        endcase
      end
    end
  end

  // PHY request per group, captured at launch and held until the answer.
  always_ff @(posedge aclk) begin
    for (int g = 0; g < GROUPS; g++) begin
      if (!aresetn) begin
        phy_req[g] <= '0;
      end else if (ctrl_reg[g][`PICA_CTRL_RST] || finish[g]) begin
        phy_req[g].valid <= 1'b0;
      end else if (launch[g]) begin
        phy_req[g].valid <= 1'b1;
        phy_req[g].write <= ctrl_next[g][`PICA_CTRL_RW];
        phy_req[g].addr  <= data_addr_next[g][`PICA_ADDR_MSB:`PICA_ADDR_LSB];
        phy_req[g].wdata <= data_addr_next[g][`PICA_DATA_MSB:`PICA_DATA_LSB];
      end
    end
  end

  // Completion events are sticky; a set in the clearing cycle wins.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_fire && (wr_idx == 3'h5)) begin
      irq_status_next = irq_status_reg & ~wdata_reg[GROUPS-1:0];
    end
    irq_status_next = irq_status_next | finish;
  end

  // Interrupt status, enable and output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= `PICA_IRQ_RST;
      irq_enable_reg <= `PICA_IRQ_RST;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_fire && (wr_idx == 3'h6) && wstrb_reg[0]) begin
        irq_enable_reg <= wdata_reg[GROUPS-1:0];
      end
      irq <= |(irq_status_next & irq_enable_reg);
    end
  end

  // Write address and data channels are taken independently and held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= `PICA_WORD_RST;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Ready on the write channels and the write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PICA_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= refused(wr_idx, 1'b1) ? `PICA_RESP_SLV : `PICA_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data selection; the state field shows the live engine state.
  always_comb begin
    rd_word = `PICA_WORD_RST;
    if (rd_idx == 3'h0) begin
      rd_word = data_addr_reg[0];
    end else if (rd_idx == 3'h1) begin
      rd_word = ctrl_view(ctrl_reg[0], state_reg[0]);
    end else if (rd_idx == 3'h2) begin
      rd_word = data_addr_reg[1];
    end else if (rd_idx == 3'h3) begin
      rd_word = ctrl_view(ctrl_reg[1], state_reg[1]);
    end else if (rd_idx == 3'h4) begin
      rd_word[GROUPS-1:0] = irq_status_reg;
    end else if (rd_idx == 3'h6) begin
      rd_word[GROUPS-1:0] = irq_enable_reg;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PICA_WORD_RST;
      s_axi_rresp   <= `PICA_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= refused(rd_idx, 1'b0) ? `PICA_RESP_SLV : `PICA_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : pica_phy_indirect_access

`default_nettype wire

// ==== test/pica_phy_model.sv ====
// Behavioural model of the PHY internal register port of one lane group.
`timescale 1ns/1ps
`default_nettype none
module pica_phy_model #(
  parameter int LAG = 1
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire pica_pkg::pica_phy_req_t req,
  output var  pica_pkg::pica_phy_rsp_t rsp
);
  import pica_pkg::*;
  logic [15:0] mem [16];
  int          cnt;
  logic        seen;
  // Answers each request once, LAG cycles after it shows; idle data lines toggle.
  always_ff @(posedge aclk) begin
    rsp.ack   <= 1'b0;
    rsp.rdata <= ~rsp.rdata;
    cnt       <= req.valid ? cnt + 1 : 0;
    seen      <= req.valid && seen;
    if (!aresetn) begin
      rsp <= '0;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'hC0D0 + 16'(i);
      end
    end else if (req.valid && !seen && cnt == LAG) begin
      rsp.ack <= 1'b1;
      seen    <= 1'b1;
      if (req.write) begin
        mem[req.addr[3:0]] <= req.wdata;
      end else begin
        rsp.rdata <= mem[req.addr[3:0]];
      end
    end
  end
endmodule : pica_phy_model
`default_nettype wire

// ==== test/pica_phy_props.sv ====
// Port checker of the indirect PHY access block.
`timescale 1ns/1ps
`default_nettype none
module pica_phy_props #(
  parameter int ADDR_W = 12,
  parameter int GROUPS = 2
) (
  input wire logic                                 aclk,
  input wire logic                                 aresetn,
  input wire logic [1:0]                           s_axi_bresp,
  input wire logic                                 s_axi_bvalid,
  input wire logic                                 s_axi_bready,
  input wire logic                                 s_axi_arvalid,
  input wire logic                                 s_axi_arready,
  input wire logic [31:0]                          s_axi_rdata,
  input wire logic                                 s_axi_rvalid,
  input wire logic                                 s_axi_rready,
  input wire pica_pkg::pica_phy_req_t [GROUPS-1:0] phy_req,
  input wire pica_pkg::pica_phy_rsp_t [GROUPS-1:0] phy_rsp,
  input wire logic                                 irq
);
  import pica_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers stand until taken and reads follow their address.
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && phy_req == '0)
    else $error("outputs active after reset");
  // Each group holds its request until answered, then drops it and rests.
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    a_req_steady: assert property (
      phy_req[g].valid && !phy_rsp[g].ack |=> phy_req[g].valid && $stable(phy_req[g]))
      else $error("phy request changed before answer");
    a_req_drops: assert property (
      phy_rsp[g].ack |-> ##[1:2] !phy_req[g].valid)
      else $error("phy request kept after answer");
    a_idle_gap: assert property (
      $fell(phy_req[g].valid) |=> !phy_req[g].valid)
      else $error("new access started without rest");
  end
  c_lo_ack: cover property (phy_rsp[0].ack);
  c_hi_ack: cover property (phy_rsp[1].ack);
  c_irq: cover property ($rose(irq));
endmodule : pica_phy_props
bind pica_phy_indirect_access pica_phy_props #(.ADDR_W(ADDR_W), .GROUPS(GROUPS)) i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .phy_req(phy_req), .phy_rsp(phy_rsp), .irq(irq));
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the indirect PHY access block.
`timescale 1ns/1ps
`default_nettype none
`include "pica_consts.svh"
module tb_top;
  import pica_pkg::*;
  localparam logic [11:0] LD = `PICA_LO_DATA_ADDR_OFF, LC = `PICA_LO_CTRL_OFF;
  localparam logic [11:0] HD = `PICA_HI_DATA_ADDR_OFF, HC = `PICA_HI_CTRL_OFF;
  localparam logic [11:0] ST = `PICA_IRQ_STATUS_OFF, CL = `PICA_IRQ_CLEAR_OFF;
  localparam logic [11:0] EN = `PICA_IRQ_ENABLE_OFF;
  localparam logic [1:0]  OK = `PICA_RESP_OKAY, SE = `PICA_RESP_SLV;
  logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0]         awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [1:0]          bresp, rresp;
  pica_phy_req_t [1:0] req;
  wire pica_phy_rsp_t [1:0] rsp;
  logic [3:0]          wstrb;
  logic                seen [2] = '{1'b0, 1'b0};
  logic [32:0]         last [2];  // Direction, data and address of the latest launch.
  int                  n_mismatch, checked, cyc;
  int                  n_launch [2] = '{0, 0};
  pica_phy_indirect_access i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phy_req(req), .phy_rsp(rsp), .irq(irq));
  pica_phy_model #(.LAG(1)) i_lo (.aclk(aclk), .aresetn(aresetn), .req(req[0]), .rsp(rsp[0]));
  pica_phy_model #(.LAG(8)) i_hi (.aclk(aclk), .aresetn(aresetn), .req(req[1]), .rsp(rsp[1]));
  // Clock of 20 ns.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Records every launch seen at the PHY side and cuts a hung run short.
  always @(posedge aclk) begin
    cyc++;
    for (int g = 0; g < 2; g++) begin
      if (req[g].valid === 1'b1 && !seen[g]) begin
        n_launch[g]++;
        last[g] = {req[g].write, req[g].wdata, req[g].addr};
      end
      seen[g] = req[g].valid === 1'b1;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d, compares %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, ad, wd;
    logic [1:0] r;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (!(ad && wd)) begin
      #1 ah = awready && !ad;
      wh = wready && !wd;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad = ad | ah;
      wd = wd | wh;
    end
    do begin
      #1 ah = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!ah);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      #1 hit = arready;
      @(posedge aclk);
    end while (!hit);
    arvalid <= 1'b0;
    do begin
      #1 hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!hit);
    rready <= 1'b0;
  endtask : axi_read
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  // Polls the event status, checks the interrupt level, then clears the events.
  task automatic wait_done(input logic [1:0] m, input logic ei);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    while ((d[1:0] & m) != m) begin
      axi_read(ST, d, r);
    end
    @(posedge aclk);
    #1 chk({31'h0, irq}, {31'h0, ei});
    wr(CL, {30'h0, m}, OK);
    @(posedge aclk);
    #1 chk({31'h0, irq}, 32'h0);
  endtask : wait_done
  // Reset values, launches by plain reads, a masked event and refused places.
  task automatic t_reset();
    rd(LC, 32'h0, OK);
    rd(HD, 32'h0, OK);
    rd(EN, 32'h0, OK);
    wait_done(2'h3, 1'b0);
    wr(EN, 32'h3, OK);
    wr(ST, 32'h1, SE);
    rd(CL, 32'h0, SE);
    wr(12'h700, 32'h1, SE);
    rd(ST, 32'h0, OK);
  endtask : t_reset
  // Lower group: stores without launch, write then read back, engine reset.
  task automatic t_lo();
    wr(LC, 32'h3, OK);
    rd(LD, 32'hC0D00000, OK);
    wr(LD, 32'h5A3C0003, OK);
    rd(LD, 32'h5A3C0003, OK);
    chk(32'(n_launch[0]), 32'h1);
    wr(LC, 32'h1, OK);
    wait_done(2'h1, 1'b1);
    chk(last[0][31:0], 32'h5A3C0003);
    chk({31'h0, last[0][32]}, 32'h1);
    rd(LC, 32'h5, OK);
    wait_done(2'h1, 1'b1);
    wr(LC, 32'h38, OK);
    wait_done(2'h1, 1'b1);
    chk({31'h0, last[0][32]}, 32'h0);
    wr(LC, 32'h2, OK);
    rd(LD, 32'h5A3C0003, OK);
    rd(LC, 32'h2, OK);
    wr(LC, 32'h40, OK);
    rd(LD, 32'h5A3C0003, OK);
    rd(LC, 32'h40, OK);
    // Only the upper two byte lanes of the data word are written here.
    wstrb <= 4'hC;
    wr(LD, 32'h1234FFFF, OK);
    wstrb <= 4'hF;
    rd(LD, 32'h12340003, OK);
    chk(32'(n_launch[0]), 32'h4);
  endtask : t_lo
  // Upper group: slow answer, a trigger while busy, independence of groups.
  task automatic t_hi();
    wr(HD, 32'h00000007, OK);
    rd(HC, 32'h00000008, OK);
    wait_done(2'h2, 1'b1);
    chk(32'(n_launch[1]), 32'h2);
    chk(last[1], 33'h000000007);
    wr(HC, 32'h2, OK);
    rd(HD, 32'hC0D70007, OK);
    chk(32'(n_launch[0]), 32'h4);
  endtask : t_hi
  // Main sequence.
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_lo();
    t_hi();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
